// ==== dv/selfprog_checker.sv ====
`timescale 1ns/1ps
module selfprog_checker #(
  parameter int WRITE_CYCLES = 410000
) (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        ctrl_wr,
  input wire logic [7:0]  ctrl_wdata,
  input wire logic [7:0]  ctrl_rdata,
  input wire logic        spm_exec,
  input wire logic        lpm_exec,
  input wire logic        lpm_valid,
  input wire logic        eeprom_busy,
  input wire logic [11:0] fetch_addr,
  input wire logic        fetch_halt
);
  logic [15:0] op_cnt;
  // Control readback fields
  wire en       = ctrl_rdata[0];
  wire page_cmd = ctrl_rdata[1] | ctrl_rdata[2];
  wire busy     = ctrl_rdata[6];
  wire page_go  = spm_exec & en & page_cmd;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Length of a timed page operation; zero outside one
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      op_cnt <= 16'h0000;
    else if (page_go)
      op_cnt <= 16'h0001;
    else if (!en)
      op_cnt <= 16'h0000;
    else if (op_cnt != 16'h0000)
      op_cnt <= op_cnt + 16'h0001;
  end

  sequence s_page_go;
    page_go;
  endsequence
  sequence s_short_cmd;
    spm_exec && en && ctrl_rdata[3:1] == 3'h0;
  endsequence
  sequence s_op_end;
    $fell(en) && $past(op_cnt) != 16'h0000;
  endsequence

  AST_LOAD_ANS: assert property (lpm_exec && !en |-> ##2 lpm_valid)
    else $error("load byte missing two cycles after load");
  AST_LOAD_SRC: assert property (lpm_valid |-> $past(lpm_exec, 2))
    else $error("load byte without a load");
  AST_CTRL_TAKE: assert property (ctrl_wr && !en && !eeprom_busy |=>
    ctrl_rdata[4:0] == $past(ctrl_wdata[4:0]))
    else $error("control write not taken");
  AST_EE_HOLD: assert property (eeprom_busy [*3] |-> !ctrl_wr)
    else $error("control write while eeprom busy");
  AST_SHORT_END: assert property (s_short_cmd |=> !en)
    else $error("fill or re-enable did not end next cycle");
  AST_BUSY_SET: assert property (s_page_go |=> busy)
    else $error("busy flag not set by page operation");
  AST_BUSY_CLR: assert property ($fell(busy) |-> $past(ctrl_rdata[4]) && $past(en))
    else $error("busy flag cleared without re-enable");
  AST_HALT_LIVE: assert property (busy && en && page_cmd && fetch_addr < 12'hC00
    |-> fetch_halt)
    else $error("live region fetch not halted");
  AST_HALT_CAUSE: assert property (fetch_halt |-> busy && en)
    else $error("halt outside a page operation");
  AST_OP_LEN: assert property (s_op_end |->
    $past(op_cnt) >= WRITE_CYCLES - 3 && $past(op_cnt) <= WRITE_CYCLES + 3)
    else $error("page operation length wrong");
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "selfprog_params.svh"
module testbench;
  localparam int WCYC = 50;
  typedef struct packed {
    logic [1:0]  cfg;
    logic [11:0] bs;
    logic [11:0] ae;
    logic [5:0]  bp;
  } row_t;
  row_t        rows [4];
  logic        mclk, rstn, ee, mem_we, cpu_halt, irq;
  logic        halt_seen;
  logic [1:0]  boot_size_cfg, bresp, rresp, resp;
  logic [11:0] mem_addr, boot_start, app_end, pc_fetch;
  logic [15:0] mem_wdata, mem_rdata;
  logic [5:0]  boot_pages;
  logic [7:0]  lock_bits;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [15:0] mem [4096];
  int          miscompares = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          we_cnt = 0;
  int          w0;

  selfprog_if bus (.mclk(mclk));
  selfprog_device #(.WRITE_CYCLES(WCYC)) i_selfprog_device (
    .mclk(mclk), .rstn(rstn), .bus(bus), .boot_size_cfg(boot_size_cfg),
    .eeprom_write_active_bit(ee), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_rdata(mem_rdata), .boot_start(boot_start),
    .app_end(app_end), .boot_pages(boot_pages), .lock_bits(lock_bits));
  selfprog_cpu i_selfprog_cpu (
    .mclk(mclk), .rstn(rstn), .bus(bus), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pc_fetch(pc_fetch), .cpu_halt(cpu_halt), .irq(irq));
  selfprog_checker #(.WRITE_CYCLES(WCYC)) i_selfprog_checker (
    .mclk(mclk), .rstn(rstn), .ctrl_wr(bus.ctrl_wr), .ctrl_wdata(bus.ctrl_wdata),
    .ctrl_rdata(bus.ctrl_rdata), .spm_exec(bus.spm_exec), .lpm_exec(bus.lpm_exec),
    .lpm_valid(bus.lpm_valid), .eeprom_busy(bus.eeprom_busy),
    .fetch_addr(bus.fetch_addr), .fetch_halt(bus.fetch_halt));

  always #5 mclk = ~mclk;
  assign mem_rdata = mem[mem_addr];

  // Flash array model, halt monitor and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
      we_cnt <= we_cnt + 1;
    end
    if (cpu_halt) halt_seen <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      resp = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    logic ta, tr;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge mclk);
      ta = arvalid & arready;
      tr = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Issue a command and poll until the sequencer is idle
  task automatic cmd(input logic [2:0] c);
    wr(`SP_A_CMD, {29'h0, c});
    got = 32'h1;
    while (got[0] === 1'b1) rd(`SP_A_STAT);
  endtask

  task automatic do_reset(input logic [1:0] c);
    @(posedge mclk);
    rstn <= 1'b0;
    boot_size_cfg <= c;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    boot_size_cfg = 2'h0;
    ee = 1'b0;
    pc_fetch = 12'hF80;
    halt_seen = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    for (int i = 0; i < 4096; i++) mem[i] = 16'hFFFF;
    rows = '{'{2'h3, 12'hF80, 12'hF7F, 6'h04}, '{2'h2, 12'hF00, 12'hEFF, 6'h08},
             '{2'h1, 12'hE00, 12'hDFF, 6'h10}, '{2'h0, 12'hC00, 12'hBFF, 6'h20}};
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    // Boot size decode, one reset per code
    foreach (rows[i]) begin
      do_reset(rows[i].cfg);
      chk(boot_start, rows[i].bs);
      chk(app_end, rows[i].ae);
      chk(boot_pages, rows[i].bp);
      boot_size_cfg <= ~rows[i].cfg;
      repeat (3) @(posedge mclk);
      chk(boot_start, rows[i].bs);
    end
    $display("Test boot_size done");
    // Values while held in reset, then the new code is caught
    rstn <= 1'b0;
    @(negedge mclk);
    chk({boot_start, app_end, lock_bits}, {12'hC00, 12'hBFF, 8'hFF});
    chk(boot_pages, 6'h20);
    @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(boot_start, 12'hF80);
    $display("Test reset done");
    // Erase and fill from the halting region, then write from the live one
    wr(`SP_A_IMASK, 32'h1);
    wr(`SP_A_ZPTR, 32'hE400);
    cmd(3'h1);
    chk(halt_seen, 1'b0);
    for (int i = 0; i < 32; i++) begin
      wr(`SP_A_DATA, {16'h0, 8'(i), 8'hA5});
      cmd(3'h3);
    end
    rd(`SP_A_ZPTR);
    chk(got[15:0], 16'hE440);
    wr(`SP_A_ZPTR, 32'hE400);
    pc_fetch <= 12'h100;
    w0 = we_cnt;
    cmd(3'h2);
    chk(we_cnt - w0, 32);
    for (int i = 0; i < 32; i++) chk(mem[12'h200 + i], {8'(i), 8'hA5});
    chk(halt_seen, 1'b1);
    rd(`SP_A_STAT);
    chk(got[2], 1'b0);
    $display("Test page_write done");
    // Byte loads of one word, top pointer bits set
    for (int i = 0; i < 2; i++) begin
      wr(`SP_A_ZPTR, 32'hE402 + i);
      cmd(3'h6);
      rd(`SP_A_STAT);
      chk(got[15:8], i ? 8'h01 : 8'hA5);
    end
    $display("Test load done");
    // Mask, raise and clear the interrupt
    wr(`SP_A_IMASK, 32'h0);
    chk(irq, 1'b0);
    wr(`SP_A_IMASK, 32'h3);
    chk(irq, 1'b1);
    rd(`SP_A_ISTAT);
    chk(got[1:0], 2'h3);
    wr(`SP_A_ISTAT, 32'h3);
    chk(irq, 1'b0);
    $display("Test irq done");
    // Lock command held back while the eeprom writes
    ee <= 1'b1;
    wr(`SP_A_CMD, 32'h4);
    repeat (20) @(posedge mclk);
    rd(`SP_A_STAT);
    chk(got[3:0], 4'h9);
    ee <= 1'b0;
    while (got[0] === 1'b1) rd(`SP_A_STAT);
    chk(got[1:0], 2'h0);
    chk(lock_bits, 8'hE7);
    $display("Test eeprom_wait done");
    // Unmapped offsets
    rd(5'h18);
    chk({resp, got}, {`SP_RESP_SLVERR, 32'h0});
    wr(5'h1C, 32'h1);
    chk(resp, `SP_RESP_SLVERR);
    $display("Test unmapped done");
    give_verdict();
  end
endmodule

// ==== rtl/selfprog_cpu.sv ====
`timescale 1ns/1ps
`include "selfprog_params.svh"
module selfprog_cpu (
  input  wire logic        mclk,
  input  wire logic        rstn,
  selfprog_if.cpu          bus,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [11:0] pc_fetch,
  output logic             cpu_halt,
  output logic             irq
);
  selfprog_pkg::seq_state_t state;
  selfprog_pkg::cmd_t       cur;
  logic [15:0] zptr;
  logic [15:0] sdata;
  logic [7:0]  lpm_byte;
  logic [1:0]  istat;
  logic [1:0]  imask;
  logic        busy_seen;
  logic [31:0] wmask;

  // Byte lane mask from write strobes
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      assign wmask[8*i+7:8*i] = {8{s_axi_wstrb[i]}};
    end
  endgenerate

  // Bus handshakes; one write and one read outstanding
  wire        wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire        rd_go  = s_axi_arvalid && !s_axi_rvalid;
  wire [31:0] wval   = s_axi_wdata & wmask;
  wire        wr_cmd = wr_go && (s_axi_awaddr == `SP_A_CMD);
  wire        wr_z   = wr_go && (s_axi_awaddr == `SP_A_ZPTR);
  wire        wr_d   = wr_go && (s_axi_awaddr == `SP_A_DATA);
  wire        wr_ist = wr_go && (s_axi_awaddr == `SP_A_ISTAT);
  wire        wr_msk = wr_go && (s_axi_awaddr == `SP_A_IMASK);
  wire        wr_ok  = wr_cmd || wr_z || wr_d || wr_ist || wr_msk ||
                       (s_axi_awaddr == `SP_A_STAT);
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign cpu_halt      = bus.fetch_halt;
  assign bus.fetch_addr = pc_fetch;
  assign irq           = |(istat & imask);

  // Sequencer conditions
  wire dev_en     = bus.ctrl_rdata[`SP_BIT_EN];
  wire live_busy  = bus.ctrl_rdata[`SP_BIT_BUSY];
  wire [2:0] code = s_axi_wdata[2:0];
  wire code_ok    = (code != 3'b000) && (code != 3'b111);
  wire page_op    = (cur == selfprog_pkg::CMD_ERASE) || (cur == selfprog_pkg::CMD_WRITE);
  wire is_read    = (cur == selfprog_pkg::CMD_READ);
  wire done_now   = (state == selfprog_pkg::S_DONE) &&
                    (is_read ? bus.lpm_valid : !dev_en);
  wire ready_evt  = busy_seen && !live_busy;
  wire [7:0] ctrl_val = (cur == selfprog_pkg::CMD_ERASE) ? `SP_CTRL_ERASE :
                        (cur == selfprog_pkg::CMD_WRITE) ? `SP_CTRL_WRITE :
                        (cur == selfprog_pkg::CMD_FILL)  ? `SP_CTRL_FILL  :
                        (cur == selfprog_pkg::CMD_LOCK)  ? `SP_CTRL_LOCK  :
                        (cur == selfprog_pkg::CMD_REEN)  ? `SP_CTRL_REEN  :
                                                           `SP_CTRL_NONE;
  // Word index forced to zero for page write, byte bit zero for stores
  wire [15:0] z_issue = (cur == selfprog_pkg::CMD_WRITE) ? {zptr[15:6], 6'h00} :
                        is_read ? zptr : {zptr[15:1], 1'b0};

  // Read data decode
  wire [31:0] next_rdata =
    (s_axi_araddr == `SP_A_ZPTR)  ? {16'h0000, zptr} :
    (s_axi_araddr == `SP_A_DATA)  ? {16'h0000, sdata} :
    (s_axi_araddr == `SP_A_STAT)  ? {16'h0000, lpm_byte, 4'h0, bus.eeprom_busy,
                                     live_busy, dev_en, state != selfprog_pkg::S_IDLE} :
    (s_axi_araddr == `SP_A_ISTAT) ? {30'h0, istat} :
    (s_axi_araddr == `SP_A_IMASK) ? {30'h0, imask} : 32'h0000_0000;
  wire rd_ok = (s_axi_araddr <= `SP_A_IMASK) && (s_axi_araddr[1:0] == 2'b00);

  // Write response and read data channels
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SP_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `SP_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SP_RESP_OKAY : `SP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_ok ? `SP_RESP_OKAY : `SP_RESP_SLVERR;
        s_axi_rdata  <= next_rdata;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software registers; events win over a same-cycle clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sdata     <= 16'h0000;
      imask     <= 2'b00;
      istat     <= 2'b00;
      busy_seen <= 1'b0;
      lpm_byte  <= 8'h00;
    end else begin
      if (wr_d) sdata <= (sdata & ~wmask[15:0]) | wval[15:0];
      if (wr_msk) imask <= (imask & ~wmask[1:0]) | wval[1:0];
      istat     <= (istat & ~(wr_ist ? wval[1:0] : 2'b00)) | {ready_evt, done_now};
      busy_seen <= live_busy;
      if (done_now && is_read) lpm_byte <= bus.lpm_data;
    end
  end

  // Command sequencer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state          <= selfprog_pkg::S_IDLE;
      cur            <= selfprog_pkg::CMD_NONE;
      zptr           <= 16'h0000;
      bus.ctrl_wr    <= 1'b0;
      bus.ctrl_wdata <= 8'h00;
      bus.spm_exec   <= 1'b0;
      bus.lpm_exec   <= 1'b0;
      bus.zptr       <= 16'h0000;
      bus.spm_data   <= 16'h0000;
    end else begin
      bus.ctrl_wr  <= 1'b0;
      bus.spm_exec <= 1'b0;
      bus.lpm_exec <= 1'b0;
      if (wr_z && state == selfprog_pkg::S_IDLE) begin
        zptr <= (zptr & ~wmask[15:0]) | wval[15:0];
      end
      unique case (state)
        selfprog_pkg::S_IDLE: begin
          if (wr_cmd && code_ok) begin
            cur   <= selfprog_pkg::cmd_t'(code);
            state <= selfprog_pkg::S_WAIT;
          end
        end
        selfprog_pkg::S_WAIT: begin
          if (!dev_en && !bus.eeprom_busy) begin
            state <= selfprog_pkg::S_CTRL;
          end
        end
        selfprog_pkg::S_CTRL: begin
          bus.ctrl_wr    <= !is_read;
          bus.ctrl_wdata <= ctrl_val;
          bus.zptr       <= z_issue;
          bus.spm_data   <= sdata;
          state          <= selfprog_pkg::S_EXEC;
        end
        selfprog_pkg::S_EXEC: begin
          bus.spm_exec <= !is_read;
          bus.lpm_exec <= is_read;
          state        <= selfprog_pkg::S_DONE;
        end
        selfprog_pkg::S_DONE: begin
          if (done_now && page_op) begin
            cur   <= selfprog_pkg::CMD_REEN;
            state <= selfprog_pkg::S_WAIT;
          end else if (done_now) begin
            if (cur == selfprog_pkg::CMD_FILL) zptr <= zptr + `SP_ZPTR_STEP;
            state <= selfprog_pkg::S_IDLE;
          end
        end
        default: state <= selfprog_pkg::S_IDLE;
      endcase
    end
  end
endmodule

// ==== rtl/selfprog_device.sv ====
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "selfprog_params.svh"
// Contract
// - Every flash write lasts 3.7 to 4.5 ms
// - Decode boot size bits into 4..32 pages
// - Boot start and application end follow size
// - Words from 0xC00 up readable while writing; code halts them too when the target page is 0x60 or above
// - Twelve-bit counter, 32-word pages
// - Page index from Z bits 12..6
// - Fill word index Z 5..1; zero on write
// - Z bits 15..13 always ignored
// - Z bit 0 zero for stores, byte select loads
// - Only halting region fetches during page ops
// - Busy flag set until region safe
// - Software waits enable clear before new command
// - Software waits EEPROM idle before commands
// - Software re-enables reads after erase or write
// - Fill buffer word by word, Z plus two
// - Page write pattern, store within four cycles
// - Busy cleared only by re-enable after completion
module selfprog_device #(
  parameter int WRITE_CYCLES = (`SP_WRITE_MIN_CYC + `SP_WRITE_MAX_CYC) / 2
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  selfprog_if.dev          bus,
  input  wire logic [1:0]  boot_size_cfg,
  input  wire logic        eeprom_write_active_bit,
  output logic [11:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  output logic             mem_we,
  input  wire logic [15:0] mem_rdata,
  output logic [11:0]      boot_start,
  output logic [11:0]      app_end,
  output logic [5:0]       boot_pages,
  output logic [7:0]       lock_bits
);
  logic        en;
  logic        erase_bit;
  logic        write_bit;
  logic        lock_bit;
  logic        reen_bit;
  logic [2:0]  window;
  logic        live_busy;
  logic        op_busy;
  logic        op_page;
  logic        op_erase;
  logic [6:0]  page_index;
  logic        walking;
  logic [4:0]  walk_idx;
  logic        lpm_pend;
  logic        lpm_hi;
  logic [1:0]  boot_size;
  logic        cfg_taken;
  logic        op_done;
  logic [15:0] page_buf [`SP_PAGE_WORDS];

  // Command decode; page ops outrank lock, re-enable and fill
  wire ctrl_take  = bus.ctrl_wr && !en && !eeprom_write_active_bit;
  wire armed      = en && !op_busy && (window != 3'h0);
  wire spm_go     = bus.spm_exec && armed;
  wire go_page    = spm_go && (erase_bit || write_bit);
  wire go_lock    = spm_go && !erase_bit && !write_bit && lock_bit;
  wire go_reen    = spm_go && !erase_bit && !write_bit && !lock_bit && reen_bit;
  wire go_fill    = spm_go && !erase_bit && !write_bit && !lock_bit && !reen_bit;
  wire expire     = armed && !bus.spm_exec && (window == 3'h1);
  wire [4:0] fill_idx = bus.zptr[5:1];
  wire [6:0] z_page   = bus.zptr[12:6];
  wire walk_last  = (walk_idx == 5'(`SP_PAGE_WORDS - 1));

  // Region checks for fetch stalling
  wire fetch_in_live  = bus.fetch_addr < `SP_HALT_START;
  wire target_halting = page_index >= `SP_HALT_PAGE;
  assign bus.fetch_halt = op_busy && op_page && (fetch_in_live || target_halting);

  // Control readback; enable stays high until the operation ends
  assign bus.ctrl_rdata = {1'b0, live_busy, 1'b0, reen_bit, lock_bit,
                           write_bit, erase_bit, en};
  assign bus.eeprom_busy = eeprom_write_active_bit;

  // Boot region decode from latched size code
  wire [11:0] next_boot_start = (boot_size == 2'b11) ? `SP_BOOT_START_11 :
                                (boot_size == 2'b10) ? `SP_BOOT_START_10 :
                                (boot_size == 2'b01) ? `SP_BOOT_START_01 :
                                                       `SP_BOOT_START_00;
  wire [5:0]  next_boot_pages = `SP_BOOT_PAGES_MAX >> boot_size;

  // Operation timer stands in for the calibrated RC oscillator
  write_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (go_page || go_lock),
    .done  (op_done)
  );

  // Size code caught once after release so regions never move
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      boot_size <= 2'b00;
      cfg_taken <= 1'b0;
    end else if (!cfg_taken) begin
      boot_size <= boot_size_cfg;
      cfg_taken <= 1'b1;
    end
  end

  // Boot outputs registered from the decode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      boot_start <= `SP_BOOT_START_00;
      app_end    <= `SP_BOOT_START_00 - 12'h001;
      boot_pages <= `SP_BOOT_PAGES_MAX;
    end else begin
      boot_start <= next_boot_start;
      app_end    <= next_boot_start - 12'h001;
      boot_pages <= next_boot_pages;
    end
  end

  // Control bits and the store window; writes while enabled are dropped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {reen_bit, lock_bit, write_bit, erase_bit, en} <= 5'h00;
      window <= 3'h0;
    end else if (ctrl_take) begin
      en        <= bus.ctrl_wdata[`SP_BIT_EN];
      erase_bit <= bus.ctrl_wdata[`SP_BIT_ERASE];
      write_bit <= bus.ctrl_wdata[`SP_BIT_WRITE];
      lock_bit  <= bus.ctrl_wdata[`SP_BIT_LOCK];
      reen_bit  <= bus.ctrl_wdata[`SP_BIT_REEN];
      window    <= `SP_SPM_WINDOW;
    end else if (op_done || expire || go_reen || go_fill) begin
      {reen_bit, lock_bit, write_bit, erase_bit, en} <= 5'h00;
      window <= 3'h0;
    end else if (spm_go) begin
      window <= 3'h0;
    end else if (armed) begin
      window <= window - 3'h1;
    end
  end

  // Busy flag: set by page ops, cleared only by re-enable once idle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      live_busy <= 1'b0;
    end else if (go_page) begin
      live_busy <= 1'b1;
    end else if (go_reen) begin
      live_busy <= 1'b0;
    end
  end

  // Operation tracking and page walk into the array
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      op_busy    <= 1'b0;
      op_page    <= 1'b0;
      op_erase   <= 1'b0;
      page_index <= 7'h00;
      walking    <= 1'b0;
      walk_idx   <= 5'h00;
    end else if (go_page || go_lock) begin
      op_busy    <= 1'b1;
      op_page    <= go_page;
      op_erase   <= erase_bit;
      page_index <= z_page;
      walking    <= go_page;
      walk_idx   <= 5'h00;
    end else begin
      if (op_done) begin
        op_busy <= 1'b0;
      end
      if (walking) begin
        walk_idx <= walk_idx + 5'h01;
        walking  <= !walk_last;
      end
    end
  end

  // Page buffer fill; store data ignored for page ops
  always_ff @(posedge mclk) begin
    if (go_fill) begin
      page_buf[fill_idx] <= bus.spm_data;
    end
  end

  // Lock op clears only the boot lock field bits that are zero in the store data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lock_bits <= `SP_LOCK_RST;
    end else if (go_lock) begin
      lock_bits[`SP_LOCK_HI:`SP_LOCK_LO] <= lock_bits[`SP_LOCK_HI:`SP_LOCK_LO] &
                                           bus.spm_data[`SP_LOCK_HI:`SP_LOCK_LO];
    end
  end

  // Array port: page walk first, loads otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mem_addr  <= 12'h000;
      mem_wdata <= 16'h0000;
      mem_we    <= 1'b0;
    end else if (walking) begin
      mem_addr  <= {page_index, walk_idx};
      mem_wdata <= op_erase ? `SP_ERASED : page_buf[walk_idx];
      mem_we    <= 1'b1;
    end else begin
      mem_we <= 1'b0;
      if (bus.lpm_exec) begin
        mem_addr <= bus.zptr[12:1];
      end
    end
  end

  // Load path; array read is combinational on mem_addr
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lpm_pend      <= 1'b0;
      lpm_hi        <= 1'b0;
      bus.lpm_data  <= 8'h00;
      bus.lpm_valid <= 1'b0;
    end else begin
      lpm_pend      <= bus.lpm_exec && !walking;
      lpm_hi        <= bus.zptr[0];
      bus.lpm_valid <= lpm_pend;
      if (lpm_pend) begin
        bus.lpm_data <= lpm_hi ? mem_rdata[15:8] : mem_rdata[7:0];
      end
    end
  end
endmodule

// ==== rtl/selfprog_if.sv ====
`timescale 1ns/1ps
interface selfprog_if (
  input wire logic mclk
);
  logic        ctrl_wr;
  logic [7:0]  ctrl_wdata;
  logic [7:0]  ctrl_rdata;
  logic        spm_exec;
  logic        lpm_exec;
  logic [15:0] zptr;
  logic [15:0] spm_data;
  logic [7:0]  lpm_data;
  logic        lpm_valid;
  logic        eeprom_busy;
  logic [11:0] fetch_addr;
  logic        fetch_halt;
  modport dev (
    input  ctrl_wr, ctrl_wdata, spm_exec, lpm_exec, zptr, spm_data, fetch_addr,
    output ctrl_rdata, lpm_data, lpm_valid, eeprom_busy, fetch_halt
  );
  modport cpu (
    output ctrl_wr, ctrl_wdata, spm_exec, lpm_exec, zptr, spm_data, fetch_addr,
    input  ctrl_rdata, lpm_data, lpm_valid, eeprom_busy, fetch_halt
  );
endinterface

// ==== rtl/selfprog_params.svh ====
`ifndef SELFPROG_PARAMS_SVH
`define SELFPROG_PARAMS_SVH
// Clock and flash write duration
`define SP_CLK_MHZ        100
`define SP_WRITE_MIN_US   3700
`define SP_WRITE_MAX_US   4500
`define SP_WRITE_MIN_CYC  (`SP_WRITE_MIN_US * `SP_CLK_MHZ)
`define SP_WRITE_MAX_CYC  (`SP_WRITE_MAX_US * `SP_CLK_MHZ)
// Store must follow a control write within this many cycles
`define SP_SPM_WINDOW     3'h4
// Control register bit positions
`define SP_BIT_EN         0
`define SP_BIT_ERASE      1
`define SP_BIT_WRITE      2
`define SP_BIT_LOCK       3
`define SP_BIT_REEN       4
`define SP_BIT_BUSY       6
// Control patterns issued by the CPU end
`define SP_CTRL_FILL      8'h01
`define SP_CTRL_ERASE     8'h03
`define SP_CTRL_WRITE     8'h05
`define SP_CTRL_LOCK      8'h09
`define SP_CTRL_REEN      8'h11
`define SP_CTRL_NONE      8'h00
// Flash geometry and region boundaries
`define SP_PAGE_WORDS     32
`define SP_HALT_START     12'hC00
`define SP_HALT_PAGE      7'h60
`define SP_BOOT_START_11  12'hF80
`define SP_BOOT_START_10  12'hF00
`define SP_BOOT_START_01  12'hE00
`define SP_BOOT_START_00  12'hC00
`define SP_BOOT_PAGES_MAX 6'h20
`define SP_ERASED         16'hFFFF
`define SP_LOCK_RST       8'hFF
`define SP_LOCK_HI        5
`define SP_LOCK_LO        2
// CPU end register offsets
`define SP_A_CMD          5'h00
`define SP_A_ZPTR         5'h04
`define SP_A_DATA         5'h08
`define SP_A_STAT         5'h0C
`define SP_A_ISTAT        5'h10
`define SP_A_IMASK        5'h14
`define SP_RESP_OKAY      2'h0
`define SP_RESP_SLVERR    2'h2
`define SP_ZPTR_STEP      16'h0002
`endif

// ==== rtl/selfprog_pkg.sv ====
package selfprog_pkg;
  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_ERASE = 3'b001,
    CMD_WRITE = 3'b010,
    CMD_FILL  = 3'b011,
    CMD_LOCK  = 3'b100,
    CMD_REEN  = 3'b101,
    CMD_READ  = 3'b110
  } cmd_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WAIT = 3'b001,
    S_CTRL = 3'b010,
    S_EXEC = 3'b011,
    S_DONE = 3'b100
  } seq_state_t;
endpackage

// ==== rtl/write_timer.sv ====
`timescale 1ns/1ps
module write_timer #(
  parameter int CYCLES = 410000
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic start,
  output logic      done
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] count;
  logic         running;

  // Free-standing up-counter; a start while running is ignored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= running && (count == LAST);
      if (start && !running) begin
        running <= 1'b1;
        count   <= '0;
      end else if (running && (count == LAST)) begin
        running <= 1'b0;
      end else if (running) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule
